// file: cabr_pkg.sv
// Shared constants for the gas amplifier and boost configuration bank.
package cabr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] OFS_SWITCH_LOAD = 8'h0C;
    localparam logic [7:0] OFS_AMP_CONFIG  = 8'h0D;
    localparam logic [7:0] OFS_BOOST       = 8'h0E;

    // Reset values.
    localparam logic [7:0] RST_SWITCH_LOAD = 8'h00;
    localparam logic [7:0] RST_AMP_CONFIG  = 8'h00;
    localparam logic [7:0] RST_BOOST       = 8'hF2;
    localparam logic [3:0] RST_PEAK_CUR    = 4'hF;
    localparam logic [3:0] RST_OUT_VOLT    = 4'h2;

    // Switch and battery load register fields.
    localparam int B_OUT_RES    = 7;
    localparam int B_FB_PATH    = 6;
    localparam int B_IN_RES     = 5;
    localparam int B_REF_SW     = 4;
    localparam int B_SW_RSVD    = 3;
    localparam int F_BATT_HI    = 2;
    localparam int F_BATT_LO    = 0;

    // Amplifier register fields.
    localparam int B_REF_BUF    = 7;
    localparam int F_REF_HI     = 6;
    localparam int F_REF_LO     = 5;
    localparam int F_GAIN_HI    = 4;
    localparam int F_GAIN_LO    = 3;
    localparam int B_TEST_DIR   = 2;
    localparam int B_TEST_EN    = 1;
    localparam int B_AMP_EN     = 0;

    // Boost register fields.
    localparam int F_PEAK_HI    = 7;
    localparam int F_PEAK_LO    = 4;
    localparam int F_VOLT_HI    = 3;
    localparam int F_VOLT_LO    = 0;

    // Highest codes that are not reserved.
    localparam logic [2:0] BATT_CODE_MAX = 3'h5;
    localparam logic [3:0] VOLT_CODE_MAX = 4'h9;

    // Pin synchroniser depth and settle count before the strap is taken.
    localparam int          SYNC_STAGES  = 3;
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;

    typedef enum logic [1:0] {
        CABR_STRAP_WAIT,
        CABR_STRAP_LOAD,
        CABR_STRAP_DONE
    } cabr_strap_t;

endpackage : cabr_pkg

// file: cabr_regs.sv
// Configuration register bank for the gas amplifier, load and boost trims.
//
// Behaviour
// - Bit 7 inserts 100 kOhm output resistor.
// - Bit 6 connects gain-selected feedback path.
// - Bit 5 inserts 1 kOhm input resistor.
// - Bit 4 routes positive input to reference.
// - Load current codes 0-5 give 10-20 mA.
// - Amplifier bit 7 enables reference buffer.
// - Bits 6:5 pick reference 1.25-5 mV.
// - Bits 4:3 pick feedback 1100/300/500/800 kOhm.
// - Bit 2 picks test pull-down or pull-up.
// - Bit 1 enables test output on pin.
// - Bit 0 enables the gas amplifier.
// - Peak current codes map 30-500 mA, reset 15.
// - Output voltage codes 0-9 map 2.7-15 V.
// - Output voltage default taken from select pin.
// - Boost resets F2, other two reset zero.
// - Software reset keeps output voltage field.
`timescale 1ns/100ps

module cabr_regs
    import cabr_pkg::*;
#(
    parameter logic [3:0] STRAP_LOW_CODE  = RST_OUT_VOLT,
    parameter logic [3:0] STRAP_HIGH_CODE = RST_OUT_VOLT
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rd_valid,
    input  wire logic              software_register_reset,
    input  wire logic              supply_select_pin,
    output logic                   out_resistor_sel,
    output logic                   feedback_path_en,
    output logic                   input_resistor_sel,
    output logic                   ref_switch_sel,
    output logic      [2:0]        battery_load_current,
    output logic                   ref_buffer_en,
    output logic      [1:0]        gas_ref_voltage,
    output logic      [1:0]        gas_feedback_gain,
    output logic                   gas_test_direction,
    output logic                   gas_test_output_en,
    output logic                   gas_amplifier_en,
    output logic      [3:0]        boost_peak_current,
    output logic      [3:0]        boost_out_voltage,
    output logic                   strap_done,
    output logic      [4:0]        battery_load_ma,
    output logic      [12:0]       gas_ref_uv,
    output logic      [10:0]       gas_feedback_kohm,
    output logic      [8:0]        boost_peak_ma,
    output logic      [7:0]        boost_out_dv,
    output logic                   reserved_code_seen
);

    // Load current in mA; reserved codes decode to zero.
    function automatic logic [4:0] batt_ma(input logic [2:0] code);
        case (code)
            3'h0:    batt_ma = 5'h0A;
            3'h1:    batt_ma = 5'h0C;
            3'h2:    batt_ma = 5'h0E;
            3'h3:    batt_ma = 5'h10;
            3'h4:    batt_ma = 5'h12;
            3'h5:    batt_ma = 5'h14;
            default: batt_ma = 5'h00;
        endcase
    endfunction : batt_ma

    // Reference voltage in microvolts.
    function automatic logic [12:0] ref_uv(input logic [1:0] code);
        case (code)
            2'h0:    ref_uv = 13'h04E2;
            2'h1:    ref_uv = 13'h09C4;
            2'h2:    ref_uv = 13'h0EA6;
            default: ref_uv = 13'h1388;
        endcase
    endfunction : ref_uv

    // Feedback resistance in kOhm.
    function automatic logic [10:0] fb_kohm(input logic [1:0] code);
        case (code)
            2'h0:    fb_kohm = 11'h44C;
            2'h1:    fb_kohm = 11'h12C;
            2'h2:    fb_kohm = 11'h1F4;
            default: fb_kohm = 11'h320;
        endcase
    endfunction : fb_kohm

    // Inductor peak current in mA.
    function automatic logic [8:0] peak_ma(input logic [3:0] code);
        case (code)
            4'h0:    peak_ma = 9'h01E;
            4'h1:    peak_ma = 9'h028;
            4'h2:    peak_ma = 9'h032;
            4'h3:    peak_ma = 9'h03C;
            4'h4:    peak_ma = 9'h050;
            4'h5:    peak_ma = 9'h064;
            4'h6:    peak_ma = 9'h082;
            4'h7:    peak_ma = 9'h0A0;
            4'h8:    peak_ma = 9'h0C8;
            4'h9:    peak_ma = 9'h0F0;
            4'hA:    peak_ma = 9'h118;
            4'hB:    peak_ma = 9'h140;
            4'hC:    peak_ma = 9'h168;
            4'hD:    peak_ma = 9'h190;
            4'hE:    peak_ma = 9'h1C2;
            default: peak_ma = 9'h1F4;
        endcase
    endfunction : peak_ma

    // Boost output in tenths of a volt; reserved codes decode to zero.
    function automatic logic [7:0] volt_dv(input logic [3:0] code);
        case (code)
            4'h0:    volt_dv = 8'h1B;
            4'h1:    volt_dv = 8'h26;
            4'h2:    volt_dv = 8'h2F;
            4'h3:    volt_dv = 8'h3C;
            4'h4:    volt_dv = 8'h5A;
            4'h5:    volt_dv = 8'h64;
            4'h6:    volt_dv = 8'h69;
            4'h7:    volt_dv = 8'h6E;
            4'h8:    volt_dv = 8'h73;
            4'h9:    volt_dv = 8'h96;
            default: volt_dv = 8'h00;
        endcase
    endfunction : volt_dv

    logic [SYNC_STAGES-1:0] pin_sync;
    logic                   pin_level;
    logic [1:0]             strap_cnt;
    cabr_strap_t            strap_state;
    logic                   wr_switch;
    logic                   wr_amp;
    logic                   wr_boost;
    logic [DATA_W-1:0]      next_rdata;

    assign wr_switch = reg_wr_en && (reg_addr == OFS_SWITCH_LOAD);
    assign wr_amp    = reg_wr_en && (reg_addr == OFS_AMP_CONFIG);
    assign wr_boost  = reg_wr_en && (reg_addr == OFS_BOOST);

    // The select pin is asynchronous and passes a three-stage chain.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_sync <= '0;
        end else begin
            pin_sync <= {pin_sync[SYNC_STAGES-2:0], supply_select_pin};
        end
    end

    // A level counts once the two late stages agree, which also filters a
    // single-cycle glitch at the cost of one more cycle of latency.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_level <= 1'b0;
        end else if (pin_sync[SYNC_STAGES-1] == pin_sync[SYNC_STAGES-2]) begin
            pin_level <= pin_sync[SYNC_STAGES-1];
        end
    end

    // Strap capture runs once after each hard reset, after the synchroniser
    // has had time to fill; a software reset does not repeat it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_state <= CABR_STRAP_WAIT;
            strap_cnt   <= '0;
            strap_done  <= 1'b0;
        end else begin
            case (strap_state)
                CABR_STRAP_WAIT: begin
                    strap_cnt <= strap_cnt + 2'h1;
                    if (strap_cnt == STRAP_WAIT) begin
                        strap_state <= CABR_STRAP_LOAD;
                    end
                end
                CABR_STRAP_LOAD: begin
                    strap_state <= CABR_STRAP_DONE;
                    strap_done  <= 1'b1;
                end
                default: begin
                    strap_state <= CABR_STRAP_DONE;
                end
            endcase
        end
    end

    // Switch and battery load register.
    always_ff @(posedge ref_clk) begin
        if (rst || software_register_reset) begin
            out_resistor_sel     <= RST_SWITCH_LOAD[B_OUT_RES];
            feedback_path_en     <= RST_SWITCH_LOAD[B_FB_PATH];
            input_resistor_sel   <= RST_SWITCH_LOAD[B_IN_RES];
            ref_switch_sel       <= RST_SWITCH_LOAD[B_REF_SW];
            battery_load_current <= RST_SWITCH_LOAD[F_BATT_HI:F_BATT_LO];
        end else if (wr_switch) begin
            out_resistor_sel     <= reg_wdata[B_OUT_RES];
            feedback_path_en     <= reg_wdata[B_FB_PATH];
            input_resistor_sel   <= reg_wdata[B_IN_RES];
            ref_switch_sel       <= reg_wdata[B_REF_SW];
            battery_load_current <= reg_wdata[F_BATT_HI:F_BATT_LO];
        end
    end

    // Amplifier configuration register.
    always_ff @(posedge ref_clk) begin
        if (rst || software_register_reset) begin
            ref_buffer_en      <= RST_AMP_CONFIG[B_REF_BUF];
            gas_ref_voltage    <= RST_AMP_CONFIG[F_REF_HI:F_REF_LO];
            gas_feedback_gain  <= RST_AMP_CONFIG[F_GAIN_HI:F_GAIN_LO];
            gas_test_direction <= RST_AMP_CONFIG[B_TEST_DIR];
            gas_test_output_en <= RST_AMP_CONFIG[B_TEST_EN];
            gas_amplifier_en   <= RST_AMP_CONFIG[B_AMP_EN];
        end else if (wr_amp) begin
            ref_buffer_en      <= reg_wdata[B_REF_BUF];
            gas_ref_voltage    <= reg_wdata[F_REF_HI:F_REF_LO];
            gas_feedback_gain  <= reg_wdata[F_GAIN_HI:F_GAIN_LO];
            gas_test_direction <= reg_wdata[B_TEST_DIR];
            gas_test_output_en <= reg_wdata[B_TEST_EN];
            gas_amplifier_en   <= reg_wdata[B_AMP_EN];
        end
    end

    // Boost peak current field.
    always_ff @(posedge ref_clk) begin
        if (rst || software_register_reset) begin
            boost_peak_current <= RST_PEAK_CUR;
        end else if (wr_boost) begin
            boost_peak_current <= reg_wdata[F_PEAK_HI:F_PEAK_LO];
        end
    end

    // Boost output voltage field. A software reset leaves it alone because
    // reloading it could step the boost rail under a running system.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boost_out_voltage <= RST_OUT_VOLT;
        end else if (strap_state == CABR_STRAP_LOAD) begin
            boost_out_voltage <= pin_level ? STRAP_HIGH_CODE
                                           : STRAP_LOW_CODE;
        end else if (wr_boost && !software_register_reset) begin
            boost_out_voltage <= reg_wdata[F_VOLT_HI:F_VOLT_LO];
        end
    end

    // Read mux; unmapped offsets and reserved bits read as zero.
    always_comb begin
        next_rdata = '0;
        if (reg_addr == OFS_SWITCH_LOAD) begin
            next_rdata[B_OUT_RES]           = out_resistor_sel;
            next_rdata[B_FB_PATH]           = feedback_path_en;
            next_rdata[B_IN_RES]            = input_resistor_sel;
            next_rdata[B_REF_SW]            = ref_switch_sel;
            next_rdata[B_SW_RSVD]           = 1'b0;
            next_rdata[F_BATT_HI:F_BATT_LO] = battery_load_current;
        end else if (reg_addr == OFS_AMP_CONFIG) begin
            next_rdata[B_REF_BUF]           = ref_buffer_en;
            next_rdata[F_REF_HI:F_REF_LO]   = gas_ref_voltage;
            next_rdata[F_GAIN_HI:F_GAIN_LO] = gas_feedback_gain;
            next_rdata[B_TEST_DIR]          = gas_test_direction;
            next_rdata[B_TEST_EN]           = gas_test_output_en;
            next_rdata[B_AMP_EN]            = gas_amplifier_en;
        end else if (reg_addr == OFS_BOOST) begin
            next_rdata[F_PEAK_HI:F_PEAK_LO] = boost_peak_current;
            next_rdata[F_VOLT_HI:F_VOLT_LO] = boost_out_voltage;
        end
    end

    // Read data is held until the next read so a slow serial shifter can
    // pick it up at leisure.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

    // Read valid is a one-cycle pulse beside the captured byte.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
        end
    end

    // Physical decode of each trim, one cycle behind its field; the extra
    // stage keeps the lookup tables away from the output pins.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            battery_load_ma <= '0;
        end else begin
            battery_load_ma <= batt_ma(battery_load_current);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gas_ref_uv <= '0;
        end else begin
            gas_ref_uv <= ref_uv(gas_ref_voltage);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gas_feedback_kohm <= '0;
        end else begin
            gas_feedback_kohm <= fb_kohm(gas_feedback_gain);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boost_peak_ma <= '0;
        end else begin
            boost_peak_ma <= peak_ma(boost_peak_current);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boost_out_dv <= '0;
        end else begin
            boost_out_dv <= volt_dv(boost_out_voltage);
        end
    end

    // Flags a reserved code so a careless host write is visible.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reserved_code_seen <= 1'b0;
        end else begin
            reserved_code_seen <= (battery_load_current > BATT_CODE_MAX) ||
                                  (boost_out_voltage > VOLT_CODE_MAX);
        end
    end

endmodule : cabr_regs

// file: cabr_host_model.sv
// Host model that drives the register strobe port.
`timescale 1ns/100ps
module cabr_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    output logic            reg_wr_en = 1'b0,
    output logic            reg_rd_en = 1'b0,
    output logic      [7:0] reg_addr = 8'h00,
    output logic      [7:0] reg_wdata = 8'h00
);
    // Released lines invert so a stale value never passes for a fresh one.
    task automatic strobe(logic w, logic [7:0] a, d, output logic [7:0] q);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = w;
        reg_rd_en = !w;
        @(negedge ref_clk);
        q = reg_rd_valid ? reg_rdata : 8'hXX;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : strobe
endmodule : cabr_host_model

// file: cabr_regs_props.sv
// Port checks for the configuration register bank.
`timescale 1ns/100ps
module cabr_regs_chk
    import cabr_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       software_register_reset,
    input wire logic       strap_done,
    input wire logic       gas_amplifier_en,
    input wire logic [2:0] battery_load_current,
    input wire logic [3:0] boost_peak_current,
    input wire logic [3:0] boost_out_voltage
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // A write counts only when no soft reset takes it away.
    sequence s_wr(logic [7:0] a);
        reg_wr_en && !software_register_reset && reg_addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        reg_rd_en && reg_addr == a;
    endsequence
    property p_load_wr;
        s_wr(OFS_SWITCH_LOAD) |=>
            battery_load_current == $past(reg_wdata[2:0]);
    endproperty
    a_load_wr: assert property (p_load_wr)
        else $error("load write");
    property p_load_rd;
        s_rd(OFS_SWITCH_LOAD) |=> reg_rdata[3] == 1'b0
            && reg_rdata[2:0] == $past(battery_load_current);
    endproperty
    a_load_rd: assert property (p_load_rd)
        else $error("load read");
    property p_amp_wr;
        s_wr(OFS_AMP_CONFIG) |=> gas_amplifier_en == $past(reg_wdata[0]);
    endproperty
    a_amp_wr: assert property (p_amp_wr)
        else $error("amp write");
    // Before the strap load a voltage write may be overwritten by the strap.
    property p_boost_wr;
        s_wr(OFS_BOOST) ##0 strap_done
            |=> boost_peak_current == $past(reg_wdata[7:4])
            && boost_out_voltage == $past(reg_wdata[3:0]);
    endproperty
    a_boost_wr: assert property (p_boost_wr)
        else $error("boost wr");
    property p_boost_rd;
        s_rd(OFS_BOOST) |=> reg_rdata[7:4] == $past(boost_peak_current)
            && reg_rdata[3:0] == $past(boost_out_voltage);
    endproperty
    a_boost_rd: assert property (p_boost_rd)
        else $error("boost rd");
    property p_soft_rst;
        software_register_reset && strap_done
            |=> boost_peak_current == RST_PEAK_CUR
            && !gas_amplifier_en && $stable(boost_out_voltage);
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft rst");
    property p_rst_vals;
        $fell(rst) |-> boost_peak_current == RST_PEAK_CUR
            && boost_out_voltage == RST_OUT_VOLT
            && battery_load_current == 3'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("rst vals");
    property p_peak_hold;
        !reg_wr_en && !software_register_reset |=> $stable(boost_peak_current);
    endproperty
    a_peak_hold: assert property (p_peak_hold)
        else $error("peak");
endmodule : cabr_regs_chk

bind cabr_regs cabr_regs_chk chk_u (.*);

// file: test_co_afe_boost_config_regs.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/100ps
module test_co_afe_boost_config_regs
    import cabr_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst, reg_wr_en, reg_rd_en, reg_rd_valid, strap_done;
    logic        software_register_reset, supply_select_pin;
    logic        out_resistor_sel, feedback_path_en, input_resistor_sel;
    logic        ref_switch_sel, ref_buffer_en, gas_test_direction;
    logic        gas_test_output_en, gas_amplifier_en, reserved_code_seen;
    logic [1:0]  gas_ref_voltage, gas_feedback_gain;
    logic [2:0]  battery_load_current;
    logic [3:0]  boost_peak_current, boost_out_voltage;
    logic [4:0]  battery_load_ma;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, boost_out_dv, d, m [3];
    logic [8:0]  boost_peak_ma;
    logic [10:0] gas_feedback_kohm;
    logic [12:0] gas_ref_uv;
    logic [31:0] seed = 32'h0000C95A;
    int          failures = 0;
    int          n_tests = 0;
    int          gk [4] = '{1100, 300, 500, 800};
    int          vd [10] = '{27, 38, 47, 60, 90, 100, 105, 110, 115, 150};
    int          pk [16] = '{30, 40, 50, 60, 80, 100, 130, 160, 200, 240,
                             280, 320, 360, 400, 450, 500};

    cabr_regs #(.STRAP_LOW_CODE(4'h3), .STRAP_HIGH_CODE(4'h9)) dut_u (.*);
    cabr_host_model host_u (.*);

    always #50 ref_clk = ~ref_clk;

    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd

    task chk(logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task tally_and_finish();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // Reserved bit 3 of the load register never holds a written one.
    function automatic logic [7:0] exp_reg(int k, logic [7:0] v);
        return (k == 0) ? (v & 8'hF7) : v;
    endfunction : exp_reg

    // Reserved codes are never sent, so their outcome stays untested.
    task automatic put(int k, logic [7:0] v);
        logic [7:0] q;
        if (k == 0 && v[2:0] > BATT_CODE_MAX)
            v[2:0] = BATT_CODE_MAX;
        if (k == 2 && v[3:0] > VOLT_CODE_MAX)
            v[3:0] = VOLT_CODE_MAX;
        host_u.strobe(1'b1, OFS_SWITCH_LOAD + 8'(k), v, q);
        m[k] = exp_reg(k, v);
    endtask : put

    task automatic check_all();
        logic [7:0] q;
        for (int k = 0; k < 3; k++) begin
            host_u.strobe(1'b0, OFS_SWITCH_LOAD + 8'(k), 8'h00, q);
            chk(q, m[k]);
        end
        chk({out_resistor_sel, feedback_path_en}, m[0][7:6]);
        chk({input_resistor_sel, ref_switch_sel}, m[0][5:4]);
        chk(battery_load_current, m[0][2:0]);
        chk({ref_buffer_en, gas_ref_voltage}, m[1][7:5]);
        chk({gas_feedback_gain, gas_test_direction}, m[1][4:2]);
        chk({gas_test_output_en, gas_amplifier_en}, m[1][1:0]);
        chk({boost_peak_current, boost_out_voltage}, m[2]);
        chk(battery_load_ma, 16'(10 + 2 * m[0][2:0]));
        chk(gas_ref_uv, 16'(1250 * (m[1][6:5] + 1)));
        chk(gas_feedback_kohm, 16'(gk[m[1][4:3]]));
        chk(boost_peak_ma, 16'(pk[m[2][7:4]]));
        chk(boost_out_dv, 16'(vd[m[2][3:0]]));
        chk(reserved_code_seen, 1'b0);
    endtask : check_all

    initial begin
        software_register_reset = 1'b0;
        for (int p = 0; p < 2; p++) begin
            supply_select_pin = (p == 0);
            rst = 1'b1;
            repeat (2) @(negedge ref_clk);
            rst = 1'b0;
            repeat (8) @(negedge ref_clk);
            chk(strap_done, 1'b1);
            m = '{8'h00, 8'h00, (p == 0) ? 8'hF9 : 8'hF3};
            check_all();
            for (int i = 0; i < 16; i++) begin
                put(0, {i[3:0], 1'b1, 3'(i % 6)});
                put(1, {i[3:0], ~i[3:0]});
                put(2, {i[3:0], 4'(i % 10)});
                check_all();
            end
            for (int i = 0; i < 40; i++) begin
                d = rnd();
                put(int'(seed[15:8]) % 3, d);
                check_all();
            end
            @(negedge ref_clk);
            software_register_reset = 1'b1;
            @(negedge ref_clk);
            software_register_reset = 1'b0;
            m[0] = 8'h00;
            m[1] = 8'h00;
            m[2][7:4] = RST_PEAK_CUR;
            check_all();
        end
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        tally_and_finish();
    end
endmodule : test_co_afe_boost_config_regs
